// ---- design/dec_capture_pair.sv ----
// Dual edge capture logic for one channel pair of a 16-bit timer.
`timescale 1ns/1ps

module dec_capture_pair #(
    parameter int CHANNEL_INDEX = 0,
    parameter int CNT_W = dec_pkg::CNT_W
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire dec_pkg::dec_cfg_t cfg,
    input wire dec_pkg::dec_cmd_t cmd,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic even_input,
    input wire logic odd_input,
    output logic capture_arm,
    output logic dual_mode_active,
    output logic period_measure,
    output logic even_channel_flag,
    output logic odd_channel_flag,
    output logic even_irq,
    output logic odd_irq,
    output logic [CNT_W-1:0] even_capture_value,
    output logic [CNT_W-1:0] odd_capture_value
);

    // Refused at elaboration: the capture registers cannot outgrow a 32-bit counter.
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
        $error("Counter width out of range.");
    end
    if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > 4 || (CHANNEL_INDEX % 2) != 0) begin : g_bad_index
        $error("Channel index must name an even channel 0..4.");
    end

    localparam bit FILTER_PRESENT = (CHANNEL_INDEX == 0) || (CHANNEL_INDEX == 2);

    logic sync1_reg;
    logic sync2_reg;
    logic filt_level;
    logic filter_on;
    logic pin_level;
    logic in_reg;
    logic in_prev_reg;
    logic rise;
    logic fall;
    logic even_hit;
    logic odd_hit;
    logic even_sel_rise;
    logic even_sel_fall;
    logic odd_sel_rise;
    logic odd_sel_fall;
    logic capture_enable;
    logic take_first;
    logic take_second;
    logic [CNT_W-1:0] even_buf_reg;
    logic [CNT_W-1:0] odd_buf_reg;
    logic even_buf_full_reg;
    logic arm_next;
    dec_pkg::dec_state_t state_reg;
    dec_pkg::dec_state_t state_next;

    // The odd pin is outside this mode entirely.
    logic unused_odd;
    assign unused_odd = odd_input;

    // Mode and measurement kind are plain decodes of the configuration.
    assign dual_mode_active = cfg.extended_features_enable && cfg.pair_dual_capture_enable;
    assign period_measure = (cfg.even_edge_select == cfg.odd_edge_select);

    // Two flops tame the asynchronous pin; only the second one is read by any logic,
    // which costs two cycles of latency on both edges alike.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (clk_en) begin
            sync1_reg <= even_input;
            sync2_reg <= sync1_reg;
        end
    end

    // Pairs without the filter do not build it; the level passes straight through.
    if (FILTER_PRESENT) begin : g_filter
        logic filt_reg;
        logic [dec_pkg::FILT_W-1:0] filt_cnt_reg;

        // A new level is validated only after it has stood filter_value + 1 cycles.
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                filt_reg <= 1'b0;
                filt_cnt_reg <= dec_pkg::FILT_RESET;
            end else if (clk_en) begin
                if (sync2_reg == filt_reg) begin
                    filt_cnt_reg <= dec_pkg::FILT_RESET;
                end else if (filt_cnt_reg >= cfg.filter_value) begin
                    filt_reg <= sync2_reg;
                    filt_cnt_reg <= dec_pkg::FILT_RESET;
                end else begin
                    filt_cnt_reg <= filt_cnt_reg + 4'h1;
                end
            end
        end

        assign filt_level = filt_reg;
        assign filter_on = (cfg.filter_value != 4'h0);
    end else begin : g_no_filter
        assign filt_level = sync2_reg;
        assign filter_on = 1'b0;
    end

    // A zero filter value bypasses the filter and saves its latency.
    assign pin_level = filter_on ? filt_level : sync2_reg;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            in_reg <= 1'b0;
            in_prev_reg <= 1'b0;
        end else if (clk_en) begin
            in_reg <= pin_level;
            in_prev_reg <= in_reg;
        end
    end

    // Both edges come from one detector, so a measured width is free of pipeline skew.
    assign rise = in_reg && !in_prev_reg;
    assign fall = !in_reg && in_prev_reg;

    assign even_sel_rise = (cfg.even_edge_select == dec_pkg::EDGE_RISE);
    assign even_sel_fall = (cfg.even_edge_select == dec_pkg::EDGE_FALL);
    assign odd_sel_rise = (cfg.odd_edge_select == dec_pkg::EDGE_RISE);
    assign odd_sel_fall = (cfg.odd_edge_select == dec_pkg::EDGE_FALL);

    // Codes other than rising or falling never match, so they capture nothing.
    assign even_hit = (even_sel_rise && rise) || (even_sel_fall && fall);
    assign odd_hit = (odd_sel_rise && rise) || (odd_sel_fall && fall);

    // The arm bit and the mode gate the taking edge itself, so a disarm in the
    // cycle before an edge cannot let one more capture through.
    assign capture_enable = capture_arm && dual_mode_active;
    assign take_first = capture_enable && (state_reg == dec_pkg::DEC_WAIT_FIRST)
        && even_hit;
    assign take_second = capture_enable && (state_reg == dec_pkg::DEC_WAIT_SECOND)
        && odd_hit && even_channel_flag;

    // Disarming or leaving dual mode drops any half-finished pair at once.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dec_pkg::DEC_IDLE: begin
                if (capture_arm && dual_mode_active) begin
                    state_next = dec_pkg::DEC_WAIT_FIRST;
                end
            end
            dec_pkg::DEC_WAIT_FIRST: begin
                if (take_first) begin
                    state_next = dec_pkg::DEC_WAIT_SECOND;
                end
            end
            dec_pkg::DEC_WAIT_SECOND: begin
                if (take_second) begin
                    // One-shot is done; continuous goes for the next pair.
                    state_next = cfg.even_mode_select_a ? dec_pkg::DEC_WAIT_FIRST
                        : dec_pkg::DEC_IDLE;
                end
            end
            default: begin
                state_next = dec_pkg::DEC_IDLE;
            end
        endcase
        if (!capture_arm || !dual_mode_active) begin
            state_next = dec_pkg::DEC_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= dec_pkg::DEC_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // A clear command outranks a set in the same cycle; a finished one-shot pair
    // disarms too, but continuous mode leaves the bit to software.
    always_comb begin
        arm_next = capture_arm;
        if (cmd.arm_set) begin
            arm_next = 1'b1;
        end
        if (cmd.arm_clear) begin
            arm_next = 1'b0;
        end
        if (take_second && !cfg.even_mode_select_a) begin
            arm_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            capture_arm <= 1'b0;
        end else if (clk_en) begin
            capture_arm <= arm_next;
        end
    end

    // A flag set in the same cycle as its clear stays set, so no captured edge is lost.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            even_channel_flag <= 1'b0;
        end else if (clk_en) begin
            if (take_first) begin
                even_channel_flag <= 1'b1;
            end else if (cmd.even_flag_clear) begin
                even_channel_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            odd_channel_flag <= 1'b0;
        end else if (clk_en) begin
            if (take_second) begin
                odd_channel_flag <= 1'b1;
            end else if (cmd.odd_flag_clear) begin
                odd_channel_flag <= 1'b0;
            end
        end
    end

    // Requests are plain levels: they fall as soon as software clears the flag.
    assign even_irq = even_channel_flag && cfg.even_channel_irq_enable;
    assign odd_irq = odd_channel_flag && cfg.odd_channel_irq_enable;

    // Even captures wait in a buffer that reaches the register at the second edge, so
    // the register always holds a completed pair while the next one is measured.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            even_buf_reg <= CNT_W'(dec_pkg::CAPT_RESET);
            even_buf_full_reg <= 1'b0;
        end else if (clk_en) begin
            if (take_first) begin
                even_buf_reg <= counter_value;
                even_buf_full_reg <= 1'b1;
            end else if (take_second) begin
                even_buf_full_reg <= 1'b0;
            end
        end
    end

    // The odd capture waits in its own buffer until software reads the even value.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            odd_buf_reg <= CNT_W'(dec_pkg::CAPT_RESET);
        end else if (clk_en) begin
            if (take_second) begin
                odd_buf_reg <= counter_value;
            end
        end
    end

    // The even register changes only at the second edge, never at the first.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            even_capture_value <= CNT_W'(dec_pkg::CAPT_RESET);
        end else if (clk_en) begin
            if (take_second && even_buf_full_reg) begin
                even_capture_value <= even_buf_reg;
            end
        end
    end

    // Software must read the even value first; that read releases the matching odd value.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            odd_capture_value <= CNT_W'(dec_pkg::CAPT_RESET);
        end else if (clk_en) begin
            if (cmd.even_value_read) begin
                odd_capture_value <= odd_buf_reg;
            end
        end
    end

endmodule // dec_capture_pair

// ---- shared/dec_pkg.sv ----
// Package of constants and carrier types for the dual edge capture pair.
package dec_pkg;

    localparam int CNT_W = 16;
    localparam int FILT_W = 4;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [15:0] CAPT_RESET = 16'h0000;
    localparam logic [3:0] FILT_RESET = 4'h0;

    typedef struct packed {
        logic extended_features_enable;
        logic pair_dual_capture_enable;
        logic even_mode_select_a;
        logic [1:0] even_edge_select;
        logic [1:0] odd_edge_select;
        logic even_channel_irq_enable;
        logic odd_channel_irq_enable;
        logic [3:0] filter_value;
    } dec_cfg_t;

    typedef struct packed {
        logic arm_set;
        logic arm_clear;
        logic even_flag_clear;
        logic odd_flag_clear;
        logic even_value_read;
    } dec_cmd_t;

    typedef enum logic [1:0] {
        DEC_IDLE = 2'b00,
        DEC_WAIT_FIRST = 2'b01,
        DEC_WAIT_SECOND = 2'b10
    } dec_state_t;

endpackage

// ---- test/dec_capture_pair_asserts.sv ----
// Checker for the dual edge capture pair.
`timescale 1ns/1ps
module dec_capture_pair_asserts (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire dec_pkg::dec_cfg_t cfg,
    input wire dec_pkg::dec_cmd_t cmd,
    input wire logic capture_arm,
    input wire logic dual_mode_active,
    input wire logic period_measure,
    input wire logic even_channel_flag,
    input wire logic odd_channel_flag,
    input wire logic even_irq,
    input wire logic odd_irq,
    input wire logic [15:0] odd_capture_value
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_dual_gate: assert property (
        dual_mode_active == (cfg.extended_features_enable && cfg.pair_dual_capture_enable))
        else $error("dual gate wrong");
    chk_period_sel: assert property (
        period_measure == (cfg.even_edge_select == cfg.odd_edge_select))
        else $error("period select wrong");
    chk_even_irq: assert property (even_irq == (even_channel_flag && cfg.even_channel_irq_enable))
        else $error("even irq wrong");
    chk_odd_irq: assert property (odd_irq == (odd_channel_flag && cfg.odd_channel_irq_enable))
        else $error("odd irq wrong");
    chk_even_armed: assert property (
        $rose(even_channel_flag) |-> $past(capture_arm) && $past(dual_mode_active))
        else $error("even flag while disarmed");
    chk_odd_after_even: assert property (
        $rose(odd_channel_flag) |-> $past(even_channel_flag) && $past(capture_arm))
        else $error("odd flag out of order");
    chk_oneshot_disarm: assert property (
        $rose(odd_channel_flag) && !cfg.even_mode_select_a |-> ##[0:1] !capture_arm)
        else $error("one-shot arm kept");
    chk_cont_arm_kept: assert property (
        $fell(capture_arm) && cfg.even_mode_select_a |-> $past(cmd.arm_clear))
        else $error("continuous arm dropped");
    chk_odd_coherent: assert property (
        $changed(odd_capture_value) |-> $past(cmd.even_value_read))
        else $error("odd value moved unread");
endmodule // dec_capture_pair_asserts

// ---- test/dec_signal_src.sv ----
// Model of the measured signal on the even pin.
`timescale 1ns/1ps
module dec_signal_src (
    input wire logic sys_clk,
    output logic even_input
);
    initial even_input = 1'b0;
    // Levels change just after a rising edge so that lengths are whole cycles.
    task automatic drive(input logic lvl, input int n);
        even_input = lvl;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
endmodule // dec_signal_src

// ---- test/tb_top.sv ----
// Self-checking bench for the dual edge capture pair.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    dec_pkg::dec_cfg_t cfg = '0;
    dec_pkg::dec_cmd_t cmd = '0;
    logic [15:0] counter_value = 16'h0000;
    logic odd_input = 1'b0;
    logic even_input, capture_arm, dual_mode_active, period_measure;
    logic even_channel_flag, odd_channel_flag, even_irq, odd_irq;
    logic [15:0] even_capture_value, odd_capture_value;
    logic [2:0] rd_d = 3'h0;
    logic [15:0] exp_q[$];
    int n_errors = 0;
    int n_tests = 0;
    dec_capture_pair DUT (.*);
    dec_signal_src src (.sys_clk(sys_clk), .even_input(even_input));
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        #1;
        counter_value = counter_value + 16'h0001;
        odd_input = 1'($urandom);
    end
    task automatic final_report();
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // The input pipeline delays both edges alike, so only the difference is exact.
    // Sampled on the falling edge, well clear of the rising edge that moves the values.
    always @(negedge sys_clk) begin
        rd_d <= {rd_d[1:0], cmd.even_value_read};
        if (rd_d[2] === 1'b1) begin
            check(odd_capture_value - even_capture_value, exp_q.pop_front());
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse_cmd(input dec_pkg::dec_cmd_t c);
        cmd = c;
        cyc(1);
        cmd = '0;
        cyc(1);
    endtask
    task automatic meas(input logic [1:0] ee, input logic [1:0] oe, input logic cont,
                        input logic [4:0] clr);
        int h;
        int l;
        int k;
        logic a;
        h = $urandom_range(20, 8);
        l = $urandom_range(20, 8);
        a = (ee == dec_pkg::EDGE_RISE);
        cfg.even_edge_select = ee;
        cfg.odd_edge_select = oe;
        cfg.even_mode_select_a = cont;
        cfg.filter_value = 4'($urandom_range(2, 0));
        cfg.even_channel_irq_enable = 1'($urandom);
        cfg.odd_channel_irq_enable = 1'($urandom);
        src.drive(~a, 4);
        pulse_cmd(clr);
        pulse_cmd(5'h10);
        cyc(3);
        src.drive(a, h);
        src.drive(~a, l);
        if (ee == oe) src.drive(a, 6);
        src.drive(~a, 8);
        for (k = 0; k < 20 && odd_channel_flag !== 1'b1; k++) cyc(1);
        check(16'(odd_channel_flag), 16'h0001);
        check(16'(capture_arm), 16'(cont));
        check(16'(period_measure), 16'(ee == oe));
        check(16'(even_irq), 16'(cfg.even_channel_irq_enable));
        check(16'(odd_irq), 16'(cfg.odd_channel_irq_enable));
        exp_q.push_back(16'(ee == oe ? h + l : h));
        pulse_cmd(5'h01);
        cyc(4);
    endtask
    initial begin
        void'($urandom(32'h8347fd5e));
        cfg.extended_features_enable = 1'b1;
        cfg.pair_dual_capture_enable = 1'b1;
        cyc(10);
        rstn = 1'b1;
        cyc(2);
        for (int i = 0; i < 8; i++) begin
            meas(i[1] ? dec_pkg::EDGE_FALL : dec_pkg::EDGE_RISE,
                 i[0] ? dec_pkg::EDGE_FALL : dec_pkg::EDGE_RISE, 1'b0, 5'h06);
        end
        meas(dec_pkg::EDGE_RISE, dec_pkg::EDGE_FALL, 1'b1, 5'h06);
        meas(dec_pkg::EDGE_RISE, dec_pkg::EDGE_FALL, 1'b1, 5'h02);
        pulse_cmd(5'h08);
        check(16'(capture_arm), 16'h0000);
        pulse_cmd(5'h06);
        src.drive(1'b1, 10);
        src.drive(1'b0, 10);
        check(16'(even_channel_flag), 16'h0000);
        cfg.extended_features_enable = 1'b0;
        pulse_cmd(5'h10);
        src.drive(1'b1, 10);
        src.drive(1'b0, 10);
        check(16'(dual_mode_active), 16'h0000);
        check(16'(even_channel_flag), 16'h0000);
        final_report();
    end
    initial begin
        #100us;
        n_errors++;
        final_report();
    end
endmodule // tb_top
bind dec_capture_pair dec_capture_pair_asserts u_chk (.*);
